// file: verilog/ftc_pkg.sv
package ftc_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_FAN_COUNT_HIGH = 8'hB0;
  localparam logic [7:0] IDX_FAN_COUNT_LOW = 8'hB1;
  localparam logic [7:0] IDX_EXPECTED_COUNT_HIGH = 8'hB2;
  localparam logic [7:0] IDX_EXPECTED_COUNT_LOW_OR_DUTY = 8'hB3;
  localparam logic [7:0] IDX_FULL_SPEED_COUNT_HIGH = 8'hB4;
  localparam logic [7:0] IDX_FULL_SPEED_COUNT_LOW = 8'hB5;
  localparam logic [7:0] IDX_UPPER_BOUNDARY_TEMPERATURE = 8'hB6;
  localparam logic [7:0] IDX_LOWER_BOUNDARY_TEMPERATURE = 8'hB7;
  localparam logic [7:0] IDX_FIRST_SEGMENT_SPEED = 8'hBA;
  localparam logic [7:0] IDX_FAN_MODE_CONFIG = 8'hC0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_FAN_COUNT = 16'h0FFF;
  localparam logic [7:0] RST_EXPECTED_HIGH = 8'h00;
  localparam logic [7:0] RST_EXPECTED_LOW = 8'h01;
  localparam logic [7:0] RST_FULL_SPEED_HIGH = 8'h03;
  localparam logic [7:0] RST_FULL_SPEED_LOW = 8'hFF;
  localparam logic [7:0] RST_UPPER_BOUNDARY = 8'h3C;
  localparam logic [7:0] RST_LOWER_BOUNDARY = 8'h1E;
  localparam logic [7:0] RST_FIRST_SEGMENT = 8'hFF;
  localparam logic [7:0] RST_FAN_MODE_CONFIG = 8'h00;
  localparam logic [7:0] RST_DUTY = 8'h00;

  // ----------------------------------------------------------------
  // Field positions of the mode configuration register and the boundary sign bit
  // ----------------------------------------------------------------
  localparam int CFG_ENCODING_LSB = 0;
  localparam int CFG_DUTY_SEL_BIT = 2;
  localparam int CFG_MANUAL_BIT = 3;
  localparam int CFG_NEG_TEMP_BIT = 4;
  localparam int CFG_SEGMENT_LSB = 6;
  localparam int SIGN_BIT = 7;

  // ----------------------------------------------------------------
  // Encodings and counts
  // ----------------------------------------------------------------
  localparam logic [1:0] ENC_SPEED = 2'b00;
  localparam logic [1:0] ENC_DUTY = 2'b01;
  localparam int SPEED_CODE_SHIFT = 5;
  localparam logic [7:0] PWM_STEPS = 8'hFF;
  localparam logic [7:0] DUTY_MAX = 8'hFF;

  typedef enum logic [1:0] {
    FTC_SEG1 = 2'b01,
    FTC_SEG2 = 2'b10,
    FTC_SEG3 = 2'b11
  } ftc_segment_t;

endpackage

// file: verilog/ftc_pwm.sv
`timescale 1ns/10ps
`default_nettype none

module ftc_pwm #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Duty in parts of 2**WIDTH-1
  input wire logic [WIDTH-1:0] duty,
  // Output
  output logic pwm_out,
  output logic period_end
);

  logic [WIDTH-1:0] phase_reg;

  // ----------------------------------------------------------------
  // Phase counter runs 0 .. 2**WIDTH-2, full scale means always on
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      phase_reg <= '0;
      period_end <= 1'b0;
    end
    else if (phase_reg == {{(WIDTH-1){1'b1}}, 1'b0})
    begin
      phase_reg <= '0;
      period_end <= 1'b1;
    end
    else
    begin
      phase_reg <= phase_reg + 1'b1;
      period_end <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pwm_out <= 1'b0;
    else
      pwm_out <= (phase_reg < duty);
  end

endmodule

`default_nettype wire

// file: verilog/ftc_fan_control.sv
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// RULE1: Reading the tachometer count high byte latches its low byte for the following read.
// RULE2: Software reads the high byte first and the low byte after to obtain one coherent count.
// RULE3: Reading the full-speed count high byte likewise latches its low byte.
// RULE4: In speed mode the two expected bytes form the sixteen-bit target tachometer count.
// RULE5: In automatic mode hardware loads the expected bytes and software writes to them are ignored.
// RULE6: In duty mode the expected high byte is reserved and has no effect on fan control.
// RULE7: In duty mode the expected low byte is the PWM duty in steps of 1/255, 255 giving full on.
// RULE8: Above the upper boundary segment one applies; below it minus hysteresis segment two.
// RULE9: Above the lower boundary segment two applies; below it minus hysteresis segment three.
// RULE10: Boundary bytes are signed two's-complement degrees from -128 to 127.
// RULE11: With negative temperatures disabled the boundary sign bits are held at zero.
// RULE12: With speed encoding a segment entry is (100-X)*32/X for X percent, zero is full speed.
// RULE13: With duty encoding a segment entry is used directly as the PWM duty.
// RULE14: Hysteresis comes from an input and the segment holds inside a hysteresis band.
module ftc_fan_control #(
  parameter int ADDR_WIDTH = 10,
  parameter int HYST_WIDTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [ADDR_WIDTH-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Measurement and table inputs
  input wire logic [15:0] fan_count_in,
  input wire logic [7:0] second_thermal_input,
  input wire logic [HYST_WIDTH-1:0] hysteresis,
  input wire logic [7:0] second_segment_speed,
  input wire logic [7:0] third_segment_speed,
  // Fan drive
  output logic pwm_out,
  output logic [1:0] segment_select
);

  logic [15:0] fan_count_reg;
  logic [7:0] fan_count_low_hold_reg;
  logic [7:0] expected_count_high_reg;
  logic [7:0] expected_count_low_or_duty_reg;
  logic [7:0] full_speed_count_high_reg;
  logic [7:0] full_speed_count_low_reg;
  logic [7:0] full_speed_low_hold_reg;
  logic [7:0] upper_boundary_temperature_reg;
  logic [7:0] lower_boundary_temperature_reg;
  logic [7:0] first_segment_speed_reg;
  logic [4:0] fan_mode_config_reg;
  logic [7:0] duty_reg;
  logic [31:0] readdata_reg;
  logic waitrequest_reg;
  ftc_pkg::ftc_segment_t seg_reg;
  ftc_pkg::ftc_segment_t seg_next;

  logic [7:0] index;
  logic read_take;
  logic write_take;
  logic wr_lane;
  logic [7:0] wr_byte;
  logic [1:0] fan_control_encoding;
  logic duty_mode;
  logic manual_control;
  logic negative_temperature_enable;
  logic [7:0] seg_entry;
  logic [15:0] full_speed_count;
  logic [23:0] scaled_count;
  logic [16:0] target_sum;
  logic [15:0] auto_target;
  logic [15:0] expected_count;
  logic period_end;
  logic pwm_raw;
  logic [7:0] pwm_duty;
  logic signed [9:0] temp_s;
  logic signed [9:0] upper_s;
  logic signed [9:0] lower_s;
  logic signed [9:0] hyst_s;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign index = avs_address[9:2];
  assign read_take = avs_read && waitrequest_reg;
  assign write_take = avs_write && !waitrequest_reg;
  assign wr_lane = avs_byteenable[0];
  assign wr_byte = avs_writedata[7:0];

  assign fan_control_encoding = fan_mode_config_reg[ftc_pkg::CFG_ENCODING_LSB +: 2];
  assign duty_mode = fan_mode_config_reg[ftc_pkg::CFG_DUTY_SEL_BIT];
  assign manual_control = fan_mode_config_reg[ftc_pkg::CFG_MANUAL_BIT];
  assign negative_temperature_enable = fan_mode_config_reg[ftc_pkg::CFG_NEG_TEMP_BIT];

  // Every access answers one cycle after it is presented
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      waitrequest_reg <= 1'b1;
    else if ((avs_read || avs_write) && waitrequest_reg)
      waitrequest_reg <= 1'b0;
    else
      waitrequest_reg <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Count sampling and coherent read latches
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      fan_count_reg <= ftc_pkg::RST_FAN_COUNT;
    else
      fan_count_reg <= fan_count_in;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      fan_count_low_hold_reg <= ftc_pkg::RST_FAN_COUNT[7:0];
    else if (read_take && index == ftc_pkg::IDX_FAN_COUNT_HIGH)
      fan_count_low_hold_reg <= fan_count_reg[7:0]; // [RULE1] [RULE2]
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      full_speed_low_hold_reg <= ftc_pkg::RST_FULL_SPEED_LOW;
    else if (read_take && index == ftc_pkg::IDX_FULL_SPEED_COUNT_HIGH)
      full_speed_low_hold_reg <= full_speed_count_low_reg; // [RULE3]
    else if (write_take && wr_lane && index == ftc_pkg::IDX_FULL_SPEED_COUNT_LOW)
      full_speed_low_hold_reg <= wr_byte;
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      readdata_reg <= '0;
    else if (read_take)
    begin
      if (index == ftc_pkg::IDX_FAN_COUNT_HIGH)
        readdata_reg <= {24'h000000, fan_count_reg[15:8]};
      else if (index == ftc_pkg::IDX_FAN_COUNT_LOW)
        readdata_reg <= {24'h000000, fan_count_low_hold_reg}; // [RULE1]
      else if (index == ftc_pkg::IDX_EXPECTED_COUNT_HIGH)
        readdata_reg <= {24'h000000, expected_count_high_reg};
      else if (index == ftc_pkg::IDX_EXPECTED_COUNT_LOW_OR_DUTY)
        readdata_reg <= {24'h000000, expected_count_low_or_duty_reg};
      else if (index == ftc_pkg::IDX_FULL_SPEED_COUNT_HIGH)
        readdata_reg <= {24'h000000, full_speed_count_high_reg};
      else if (index == ftc_pkg::IDX_FULL_SPEED_COUNT_LOW)
        readdata_reg <= {24'h000000, full_speed_low_hold_reg}; // [RULE3]
      else if (index == ftc_pkg::IDX_UPPER_BOUNDARY_TEMPERATURE)
        readdata_reg <= {24'h000000, upper_boundary_temperature_reg};
      else if (index == ftc_pkg::IDX_LOWER_BOUNDARY_TEMPERATURE)
        readdata_reg <= {24'h000000, lower_boundary_temperature_reg};
      else if (index == ftc_pkg::IDX_FIRST_SEGMENT_SPEED)
        readdata_reg <= {24'h000000, first_segment_speed_reg};
      else if (index == ftc_pkg::IDX_FAN_MODE_CONFIG)
        readdata_reg <= {24'h000000, seg_reg, 1'b0, fan_mode_config_reg};
      else
        readdata_reg <= '0;
    end
  end

  assign avs_readdata = readdata_reg;
  assign avs_waitrequest = waitrequest_reg;

  // ----------------------------------------------------------------
  // Software configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      fan_mode_config_reg <= ftc_pkg::RST_FAN_MODE_CONFIG[4:0];
    else if (write_take && wr_lane && index == ftc_pkg::IDX_FAN_MODE_CONFIG)
      fan_mode_config_reg <= wr_byte[4:0];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      full_speed_count_high_reg <= ftc_pkg::RST_FULL_SPEED_HIGH;
      full_speed_count_low_reg <= ftc_pkg::RST_FULL_SPEED_LOW;
    end
    else if (write_take && wr_lane)
    begin
      if (index == ftc_pkg::IDX_FULL_SPEED_COUNT_HIGH)
        full_speed_count_high_reg <= wr_byte;
      else if (index == ftc_pkg::IDX_FULL_SPEED_COUNT_LOW)
        full_speed_count_low_reg <= wr_byte;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      first_segment_speed_reg <= ftc_pkg::RST_FIRST_SEGMENT;
    else if (write_take && wr_lane && index == ftc_pkg::IDX_FIRST_SEGMENT_SPEED)
      first_segment_speed_reg <= wr_byte;
  end

  // Sign bit is forced clear while negative temperatures are disabled
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      upper_boundary_temperature_reg <= ftc_pkg::RST_UPPER_BOUNDARY;
      lower_boundary_temperature_reg <= ftc_pkg::RST_LOWER_BOUNDARY;
    end
    else
    begin
      if (write_take && wr_lane && index == ftc_pkg::IDX_UPPER_BOUNDARY_TEMPERATURE)
        upper_boundary_temperature_reg <=
          {wr_byte[7] & negative_temperature_enable, wr_byte[6:0]}; // [RULE11]
      else if (!negative_temperature_enable)
        upper_boundary_temperature_reg[ftc_pkg::SIGN_BIT] <= 1'b0; // [RULE11]
      if (write_take && wr_lane && index == ftc_pkg::IDX_LOWER_BOUNDARY_TEMPERATURE)
        lower_boundary_temperature_reg <=
          {wr_byte[7] & negative_temperature_enable, wr_byte[6:0]}; // [RULE11]
      else if (!negative_temperature_enable)
        lower_boundary_temperature_reg[ftc_pkg::SIGN_BIT] <= 1'b0; // [RULE11]
    end
  end

  // ----------------------------------------------------------------
  // Temperature segment selection with hysteresis
  // ----------------------------------------------------------------
  assign temp_s = 10'(signed'(second_thermal_input)); // [RULE10]
  assign upper_s = 10'(signed'(upper_boundary_temperature_reg)); // [RULE10]
  assign lower_s = 10'(signed'(lower_boundary_temperature_reg)); // [RULE10]
  assign hyst_s = signed'(10'(hysteresis)); // [RULE14]

  always_comb
  begin
    seg_next = seg_reg;
    case (seg_reg)
      ftc_pkg::FTC_SEG1:
      begin
        if (temp_s < upper_s - hyst_s)
        begin
          if (temp_s < lower_s - hyst_s)
            seg_next = ftc_pkg::FTC_SEG3; // [RULE9]
          else
            seg_next = ftc_pkg::FTC_SEG2; // [RULE8]
        end
      end
      ftc_pkg::FTC_SEG2:
      begin
        if (temp_s > upper_s)
          seg_next = ftc_pkg::FTC_SEG1; // [RULE8]
        else if (temp_s < lower_s - hyst_s)
          seg_next = ftc_pkg::FTC_SEG3; // [RULE9]
      end
      ftc_pkg::FTC_SEG3:
      begin
        if (temp_s > upper_s)
          seg_next = ftc_pkg::FTC_SEG1; // [RULE8]
        else if (temp_s > lower_s)
          seg_next = ftc_pkg::FTC_SEG2; // [RULE9]
      end
      default:
        seg_next = ftc_pkg::FTC_SEG3;
    endcase
  end

  // Inside a band the current segment is kept
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      seg_reg <= ftc_pkg::FTC_SEG3;
    else
      seg_reg <= seg_next; // [RULE14]
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      segment_select <= ftc_pkg::FTC_SEG3;
    else
      segment_select <= seg_next;
  end

  // ----------------------------------------------------------------
  // Target from the table entry
  // ----------------------------------------------------------------
  always_comb
  begin
    case (seg_reg)
      ftc_pkg::FTC_SEG1: seg_entry = first_segment_speed_reg; // [RULE8]
      ftc_pkg::FTC_SEG2: seg_entry = second_segment_speed;
      default: seg_entry = third_segment_speed; // [RULE9]
    endcase
  end

  // Count grows as 100/X, so target = full + full*entry/32
  assign full_speed_count = {full_speed_count_high_reg, full_speed_count_low_reg};
  assign scaled_count = full_speed_count * seg_entry; // [RULE12]
  assign target_sum = {1'b0, full_speed_count} +
    {1'b0, scaled_count[ftc_pkg::SPEED_CODE_SHIFT +: 16]}; // [RULE12]
  assign auto_target = (target_sum[16] || scaled_count[23:21] != 3'b000) ?
    16'hFFFF : target_sum[15:0];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      expected_count_high_reg <= ftc_pkg::RST_EXPECTED_HIGH;
      expected_count_low_or_duty_reg <= ftc_pkg::RST_EXPECTED_LOW;
    end
    else if (!manual_control)
    begin
      // Software writes are dropped here
      if (fan_control_encoding == ftc_pkg::ENC_DUTY)
        expected_count_low_or_duty_reg <= seg_entry; // [RULE5] [RULE13]
      else if (fan_control_encoding == ftc_pkg::ENC_SPEED)
      begin
        expected_count_high_reg <= auto_target[15:8]; // [RULE5] [RULE12]
        expected_count_low_or_duty_reg <= auto_target[7:0]; // [RULE5]
      end
    end
    else if (write_take && wr_lane)
    begin
      if (index == ftc_pkg::IDX_EXPECTED_COUNT_HIGH)
        expected_count_high_reg <= wr_byte;
      else if (index == ftc_pkg::IDX_EXPECTED_COUNT_LOW_OR_DUTY)
        expected_count_low_or_duty_reg <= wr_byte;
    end
  end

  // ----------------------------------------------------------------
  // Fan drive
  // ----------------------------------------------------------------
  assign expected_count = {expected_count_high_reg, expected_count_low_or_duty_reg}; // [RULE4]

  // Speed mode closes the loop once per PWM period; a larger count means slower
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      duty_reg <= ftc_pkg::RST_DUTY;
    else if (period_end && !duty_mode)
    begin
      if (fan_count_reg > expected_count && duty_reg != ftc_pkg::DUTY_MAX)
        duty_reg <= duty_reg + 8'h01; // [RULE4]
      else if (fan_count_reg < expected_count && duty_reg != 8'h00)
        duty_reg <= duty_reg - 8'h01; // [RULE4]
    end
  end

  // Duty mode ignores the high byte entirely
  assign pwm_duty = duty_mode ? expected_count_low_or_duty_reg : duty_reg; // [RULE6] [RULE7]

  ftc_pwm #(
    .WIDTH(8)
  ) u_pwm (
    .clk(clk),
    .rst(rst),
    .duty(pwm_duty), // [RULE7]
    .pwm_out(pwm_raw),
    .period_end(period_end)
  );

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pwm_out <= 1'b0;
    else
      pwm_out <= pwm_raw;
  end

endmodule

`default_nettype wire

// file: bench/ftc_fan_control_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module ftc_fan_control_asserts #(
  parameter int ADDR_WIDTH = 10,
  parameter int HYST_WIDTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire logic [ADDR_WIDTH-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Control
  input wire logic [7:0] second_thermal_input,
  input wire logic [HYST_WIDTH-1:0] hysteresis,
  input wire logic pwm_out,
  input wire logic [1:0] segment_select
);
  // --------
  // Register shadow
  // --------
  logic [7:0] idx;
  logic wr_ok;
  logic duty_on;
  logic [7:0] up_reg, lo_reg, duty_reg;
  logic [2:0] cfg_reg;
  logic [9:0] full_n_reg, zero_n_reg;
  logic signed [9:0] t, up, lo, upm, lom;

  assign idx = avs_address[9:2];
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign duty_on = cfg_reg[1] && cfg_reg[0];
  assign t = {{2{second_thermal_input[7]}}, second_thermal_input};
  assign up = {{2{up_reg[7]}}, up_reg};
  assign lo = {{2{lo_reg[7]}}, lo_reg};
  assign upm = up - 10'(hysteresis);
  assign lom = lo - 10'(hysteresis);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      up_reg <= 8'h3C;
      lo_reg <= 8'h1E;
      duty_reg <= 8'h80;
      cfg_reg <= 3'h0;
    end
    else
    begin
      if (wr_ok && idx == 8'hB6)
        up_reg <= avs_writedata[7:0];
      if (wr_ok && idx == 8'hB7)
        lo_reg <= avs_writedata[7:0];
      // Mid value until written in manual mode
      if (!cfg_reg[1])
        duty_reg <= 8'h80;
      else if (wr_ok && idx == 8'hB3)
        duty_reg <= avs_writedata[7:0];
      if (wr_ok && idx == 8'hC0)
        cfg_reg <= avs_writedata[4:2];
      if (!cfg_reg[2])
      begin
        up_reg[7] <= 1'b0;
        lo_reg[7] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      full_n_reg <= 10'h000;
      zero_n_reg <= 10'h000;
    end
    else
    begin
      full_n_reg <= (duty_on && duty_reg == 8'hFF) ? full_n_reg + 10'(full_n_reg != 10'h3FF) : 10'h000;
      zero_n_reg <= (duty_on && duty_reg == 8'h00) ? zero_n_reg + 10'(zero_n_reg != 10'h3FF) : 10'h000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_wait_answer;
    s_req |=> s_ans;
  endproperty
  a_wait_answer: assert property (p_wait_answer)
    else $error("late answer");
  property p_wait_idle;
    !(avs_read || avs_write) |=> avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("idle answer");
  property p_unmapped;
    avs_read && !avs_waitrequest && !(idx inside {[8'hB0:8'hB7], 8'hBA, 8'hC0})
      |-> avs_readdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_bound_read;
    avs_read && !avs_waitrequest && idx inside {8'hB6, 8'hB7}
      |-> avs_readdata == {24'h000000, (idx == 8'hB6) ? up_reg : lo_reg};
  endproperty
  a_bound_read: assert property (p_bound_read)
    else $error("boundary read");
  property p_seg_one;
    t > up |-> ##[1:2] segment_select == 2'b01;
  endproperty
  a_seg_one: assert property (p_seg_one)
    else $error("segment one missed");
  property p_seg_three;
    t < lom |-> ##[1:2] segment_select == 2'b11;
  endproperty
  a_seg_three: assert property (p_seg_three)
    else $error("segment three missed");
  property p_seg1_hold;
    segment_select == 2'b01 && t >= upm |=> segment_select == 2'b01;
  endproperty
  a_seg1_hold: assert property (p_seg1_hold)
    else $error("segment one left");
  property p_seg2_hold;
    segment_select == 2'b10 && t <= up && t >= lom |=> segment_select == 2'b10;
  endproperty
  a_seg2_hold: assert property (p_seg2_hold)
    else $error("segment two left");
  property p_duty_full;
    full_n_reg >= 10'h208 |-> pwm_out;
  endproperty
  a_duty_full: assert property (p_duty_full)
    else $error("full duty low");
  property p_duty_zero;
    zero_n_reg >= 10'h208 |-> !pwm_out;
  endproperty
  a_duty_zero: assert property (p_duty_zero)
    else $error("zero duty high");
endmodule

bind ftc_fan_control ftc_fan_control_asserts #(
  .ADDR_WIDTH(ADDR_WIDTH), .HYST_WIDTH(HYST_WIDTH)
) u_asserts (
  .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .second_thermal_input(second_thermal_input), .hysteresis(hysteresis),
  .pwm_out(pwm_out), .segment_select(segment_select)
);

`default_nettype wire

// file: bench/ftc_fan_model.sv
`timescale 1ns/10ps
`default_nettype none

module ftc_fan_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Drive and wanted count
  input wire logic pwm_in,
  input wire logic [15:0] set_count,
  // Count and on-cycle tally
  output logic [15:0] tach_count,
  output logic [15:0] on_cycles
);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tach_count <= 16'h0FFF;
      on_cycles <= 16'h0000;
    end
    else
    begin
      tach_count <= set_count;
      on_cycles <= on_cycles + 16'(pwm_in);
    end
  end
endmodule

`default_nettype wire

// file: bench/test_fan_two_speed_table_control.sv
`timescale 1ns/10ps
`default_nettype none

module test_fan_two_speed_table_control;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] set_count = 16'h0FFF;
  logic [15:0] fan_count, on_cycles;
  logic [7:0] temp = 8'h00;
  logic [3:0] hyst = 4'h4;
  logic [7:0] seg2_entry = 8'h60;
  logic [7:0] seg3_entry = 8'h20;
  logic pwm;
  logic [1:0] seg;
  int n_fail = 0;
  int checks_done = 0;

  always #10 clk = ~clk;

  ftc_fan_control uut (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .fan_count_in(fan_count), .second_thermal_input(temp), .hysteresis(hyst),
    .second_segment_speed(seg2_entry), .third_segment_speed(seg3_entry),
    .pwm_out(pwm), .segment_select(seg)
  );
  ftc_fan_model fan (
    .clk(clk), .rst(rst), .pwm_in(pwm), .set_count(set_count),
    .tach_count(fan_count), .on_cycles(on_cycles)
  );

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] got);
    checks_done++;
    if (got !== e)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, e, got);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask

  // --------
  // Bus access
  // --------
  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     output logic [7:0] q);
    int n = 0;
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      chk("waitrequest", 8'h00, 8'h01);
      complete_run;
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, idx, d, q);
  endtask

  task automatic rc(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] q;
    acc(1'b0, idx, 8'h00, q);
    chk($sformatf("register %h", idx), e, q);
  endtask

  function automatic logic [15:0] target(input logic [15:0] f, input logic [7:0] c);
    logic [23:0] s;
    s = f + ((f * c) >> 5);
    return (s > 24'h00FFFF) ? 16'hFFFF : s[15:0];
  endfunction

  // --------
  // Scenarios
  // --------
  task automatic t_reset;
    logic [7:0] ids [9] = '{8'hB0, 8'hB1, 8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hBA, 8'hC0, 8'hB8};
    logic [7:0] vals [9] = '{8'h0F, 8'hFF, 8'h03, 8'hFF, 8'h3C, 8'h1E, 8'hFF, 8'hC0, 8'h00};
    for (int i = 0; i < 9; i++)
      rc(ids[i], vals[i]);
    $display("test reset done");
  endtask

  task automatic t_latch;
    set_count <= 16'h12AB;
    wait_n(4);
    rc(8'hB0, 8'h12);
    set_count <= 16'h34CD;
    wait_n(4);
    rc(8'hB1, 8'hAB);
    wr(8'hB0, 8'h77);
    rc(8'hB0, 8'h34);
    rc(8'hB1, 8'hCD);
    wr(8'hB4, 8'h05);
    wr(8'hB5, 8'h67);
    rc(8'hB4, 8'h05);
    rc(8'hB5, 8'h67);
    $display("test latch done");
  endtask

  task automatic t_speed;
    logic [15:0] e;
    e = target(16'h0567, 8'h20);
    wr(8'hB2, 8'hAA);
    wr(8'hB3, 8'h55);
    wait_n(4);
    rc(8'hB2, e[15:8]);
    rc(8'hB3, e[7:0]);
    seg3_entry <= 8'h00;
    wait_n(4);
    rc(8'hB2, 8'h05);
    rc(8'hB3, 8'h67);
    wr(8'hC0, 8'h08);
    wr(8'hB2, 8'h12);
    wr(8'hB3, 8'h34);
    rc(8'hB2, 8'h12);
    rc(8'hB3, 8'h34);
    $display("test speed done");
  endtask

  task automatic t_segments;
    logic [7:0] ts [8] = '{8'h00, 8'h3D, 8'h39, 8'h37, 8'h1C, 8'h19, 8'h1E, 8'h1F};
    logic [1:0] ss [8] = '{2'h3, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h2};
    logic [7:0] es [8] = '{8'h30, 8'h90, 8'h90, 8'h60, 8'h60, 8'h30, 8'h30, 8'h60};
    seg3_entry <= 8'h30;
    wr(8'hBA, 8'h90);
    wr(8'hC0, 8'h01);
    for (int i = 0; i < 8; i++)
    begin
      temp <= ts[i];
      wait_n(4);
      chk("segment", {6'h00, ss[i]}, {6'h00, seg});
      rc(8'hB3, es[i]);
    end
    $display("test segments done");
  endtask

  task automatic t_signed;
    temp <= 8'h00;
    wr(8'hB6, 8'h90);
    rc(8'hB6, 8'h10);
    wr(8'hC0, 8'h11);
    wr(8'hB7, 8'hEC);
    wr(8'hB6, 8'hF6);
    rc(8'hB6, 8'hF6);
    chk("segment", 8'h01, {6'h00, seg});
    temp <= 8'hE0;
    wait_n(4);
    chk("segment", 8'h03, {6'h00, seg});
    wr(8'hB6, 8'h3C);
    wr(8'hB7, 8'h1E);
    temp <= 8'h00;
    $display("test signed done");
  endtask

  task automatic duty(input logic [7:0] d);
    logic [15:0] s;
    wr(8'hB3, d);
    wait_n(300);
    s = on_cycles;
    wait_n(255);
    chk("pwm high cycles", d, 8'(on_cycles - s));
  endtask

  task automatic t_duty;
    wr(8'hC0, 8'h0C);
    duty(8'hFF);
    duty(8'h00);
    wr(8'hB2, 8'hAA);
    duty(8'h05);
    $display("test duty done");
  endtask

  initial
  begin
    wait_n(8);
    rst <= 1'b0;
    t_reset;
    t_latch;
    t_speed;
    t_segments;
    t_signed;
    t_duty;
    complete_run;
  end

  initial
  begin
    wait_n(100000);
    chk("run length", 8'h00, 8'h01);
    complete_run;
  end
endmodule

`default_nettype wire
